/* File: src/sync_serial_pkg.sv */
// Constants shared by the combined SPI / I2C serial port.
// Assumes a 32-bit APB bus with byte addresses and 8-bit registers.
package sync_serial_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int         ADDR_W   = 8;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_TOUT = 8'h10;
    localparam logic [7:0] OFS_PINS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MD_MODE_LO = 5;
    localparam int MD_ASYNC   = 4;
    localparam int MD_DEB_LO  = 2;
    localparam int MD_EN      = 1;
    localparam int MD_ICF     = 0;
    localparam int SC_IDLELOW = 5;
    localparam int SC_EDGE    = 4;
    localparam int SC_MSB     = 3;
    localparam int SC_SELEN   = 2;
    localparam int SC_WRITE_COLLISION_FLAG    = 1;
    localparam int SC_DONE    = 0;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MODE   = 8'he0;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_STAT   = 8'h81;
    localparam logic [7:0] RST_TOUT   = 8'h00;
    localparam logic [7:0] RST_PINS   = 8'h00;
    localparam logic [7:0] RST_DATA   = 8'h00;
    localparam logic [7:0] STAT_WMASK = 8'h1a;

    // ------------------------------------------------------------
    // Modes and timing counts
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_DIV4  = 3'h0;
    localparam logic [2:0] MODE_DIV16 = 3'h1;
    localparam logic [2:0] MODE_DIV64 = 3'h2;
    localparam logic [2:0] MODE_SUB   = 3'h3;
    localparam logic [2:0] MODE_TMR   = 3'h4;
    localparam logic [2:0] MODE_SLAVE = 3'h5;
    localparam logic [2:0] MODE_I2C   = 3'h6;
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [2:0] DEB_TWO    = 3'h2;
    localparam logic [2:0] DEB_FOUR   = 3'h4;
    localparam logic [3:0] LAST_BIT   = 4'h7;
    localparam logic [3:0] LAST_HALF  = 4'hf;

endpackage

/* File: src/sync_serial_port.sv */
// Combined synchronous serial port: SPI master/slave and I2C slave front end.
// Assumes an APB master on clk; pins are synchronised here, pads resolve enables.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

// Operation
// - Slave with select pin disabled is always active, ignoring select level.
// - Master: writing the data register starts one full-duplex word.
// - Slave: each SCK pulse shifts buffer out on SDO, SDI in.
// - Disabled unit releases SCK, SDI, SDO and select pins to pin mux.
// - With select pin disabled the select input has no effect.
// - Enabled with select pin enabled and idle: SDI input, SDO high.
// - Master idle holds SCK at polarity-chosen idle level.
// - Slave never drives SCK.
// - Master makes the serial clock; slave uses the external clock.
// - Received bits reach the data register only when the word completes.
// - Data write during transfer is dropped and sets collision flag.
// - Word end sets done flag; software reads data, clears flag.
// - I2C drives SDA and SCL only as open drain.
// - I2C is slave only, selected by address, no chip select.
// - Pull-up control on SCL/SDA stays usable in I2C mode.
// - I2C clock filtered by none, two or four clock debounce.
// - I2C status and time-out registers only reachable in I2C mode.
// - Mode field selects master clock source, SPI slave or I2C slave.
// - Debounce field: 00 none, 01 two clocks, 1x four clocks.
// - Polarity and edge bits pick SCK idle level and capture edge.
// - Slave deselected mid-word sets incomplete flag with done flag.
module sync_serial_port
(
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           ce,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [sync_serial_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           sckIn,
    output logic                                sckOut,
    output logic                                sckOe,
    input  wire logic                           sdiIn,
    output logic                                sdoOut,
    output logic                                sdoOe,
    input  wire logic                           slaveSelectN,
    input  wire logic                           subClk,
    input  wire logic                           timerMatch,
    input  wire logic                           sdaIn,
    output logic                                sdaOut,
    output logic                                sdaOe,
    input  wire logic                           sclIn,
    output logic                                sclOut,
    output logic                                sclOe,
    output logic                                sclLevel,
    output logic      [1:0]                     pullUpEn,
    output logic                                pinSerialSel
);
    import sync_serial_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic isAt(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic msb,
                                           input logic b);
        return msb ? {s[6:0], b} : {b, s[7:1]};
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic       sckS, sdiS, ssnS, subS, sclS;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA <= 5'h00;
            syncB <= 5'h00;
        end else if (ce) begin
            syncA <= {sclIn, subClk, slaveSelectN, sdiIn, sckIn};
            syncB <= syncA;
        end
    end

    assign {sclS, subS, ssnS, sdiS, sckS} = syncB;

    // ------------------------------------------------------------
    // Registers and decoded modes
    // ------------------------------------------------------------
    logic [7:0] modeReg, ctrlReg, statReg, toutReg, pinsReg, dataReg;
    logic [2:0] mode;
    logic       en, isMaster, isSlave, isI2c, idleLow, edgeSel, msbFirst, selEn;

    assign mode     = modeReg[MD_MODE_LO+:3];
    assign en       = modeReg[MD_EN] && !modeReg[MD_ASYNC];
    assign isMaster = en && mode <= MODE_TMR;
    assign isSlave  = en && mode == MODE_SLAVE;
    assign isI2c    = en && mode == MODE_I2C;
    assign idleLow  = ctrlReg[SC_IDLELOW];
    assign edgeSel  = ctrlReg[SC_EDGE];
    assign msbFirst = ctrlReg[SC_MSB];
    assign selEn    = ctrlReg[SC_SELEN];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic       acc, commit, mapped, wrMode, wrCtrl, wrStat, wrTout, wrPins, wrData;
    logic [7:0] rd;

    assign acc    = psel && penable;
    assign mapped = isAt(paddr, OFS_MODE) || isAt(paddr, OFS_STAT) ||
                    isAt(paddr, OFS_DATA) || isAt(paddr, OFS_CTRL) ||
                    isAt(paddr, OFS_TOUT) || isAt(paddr, OFS_PINS);
    assign commit = acc && pready && pwrite && mapped;
    assign wrMode = commit && isAt(paddr, OFS_MODE);
    assign wrCtrl = commit && isAt(paddr, OFS_CTRL);
    assign wrStat = commit && isAt(paddr, OFS_STAT) && isI2c;
    assign wrTout = commit && isAt(paddr, OFS_TOUT) && isI2c;
    assign wrPins = commit && isAt(paddr, OFS_PINS);
    assign wrData = commit && isAt(paddr, OFS_DATA);

    always_comb begin
        rd = 8'h00;
        if (isAt(paddr, OFS_MODE)) rd = modeReg;
        if (isAt(paddr, OFS_CTRL)) rd = ctrlReg;
        if (isAt(paddr, OFS_DATA)) rd = dataReg;
        if (isAt(paddr, OFS_PINS)) rd = pinsReg;
        if (isAt(paddr, OFS_STAT) && isI2c) rd = statReg;
        if (isAt(paddr, OFS_TOUT) && isI2c) rd = toutReg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !mapped;
            if (acc && !pready) begin
                prdata <= {24'h00_0000, rd};
            end
        end
    end

    // ------------------------------------------------------------
    // Serial clock events
    // ------------------------------------------------------------
    logic       busy, sckPrev, subPrev, halfTick, slvSel, busyAny;
    logic       lead, trail, capture, launch, start, wordDone, earlyDesel;
    logic [5:0] divCnt, halfLen;
    logic [3:0] halfCnt, bitCnt;
    logic [7:0] sh, rxWord;

    always_comb begin
        halfLen  = HALF_DIV64;
        halfTick = 1'b0;
        case (mode)
            MODE_DIV4:  begin
                halfLen  = HALF_DIV4;
                halfTick = divCnt == halfLen - 6'h01;
            end
            MODE_DIV16: begin
                halfLen  = HALF_DIV16;
                halfTick = divCnt == halfLen - 6'h01;
            end
            MODE_DIV64: halfTick = divCnt == halfLen - 6'h01;
            MODE_SUB:   halfTick = subS != subPrev;
            MODE_TMR:   halfTick = timerMatch;
            default:    halfTick = 1'b0;
        endcase
    end

    // Slave is live whenever select pin is off, else only while selected
    assign slvSel  = isSlave && (!selEn || !ssnS);
    assign busyAny = isMaster ? busy : (isSlave && bitCnt != 4'h0);

    // Master makes its own edges, slave follows the external clock
    always_comb begin
        if (isMaster) begin
            lead  = busy && halfTick && !halfCnt[0];
            trail = busy && halfTick && halfCnt[0];
        end else begin
            lead  = slvSel && sckS != sckPrev && sckPrev == !idleLow;
            trail = slvSel && sckS != sckPrev && sckPrev == idleLow;
        end
    end

    assign capture    = edgeSel ? lead : trail;
    assign launch     = edgeSel ? trail : lead;
    assign start      = wrData && isMaster && !busy;
    assign wordDone   = capture && bitCnt == LAST_BIT;
    assign earlyDesel = isSlave && selEn && ssnS && bitCnt != 4'h0;
    assign rxWord     = shiftIn(sh, msbFirst, sdiS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sckPrev <= 1'b0;
            subPrev <= 1'b0;
        end else if (ce) begin
            sckPrev <= sckS;
            subPrev <= subS;
        end
    end

    // ------------------------------------------------------------
    // Master clock generator
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy    <= 1'b0;
            halfCnt <= 4'h0;
            divCnt  <= 6'h00;
            sckOut  <= 1'b1;
        end else if (ce) begin
            if (start) begin
                busy    <= 1'b1;
                halfCnt <= 4'h0;
                divCnt  <= 6'h00;
                sckOut  <= !idleLow;
            end else if (!isMaster || !busy) begin
                busy   <= 1'b0;
                divCnt <= 6'h00;
                sckOut <= !idleLow;
            end else begin
                divCnt <= halfTick ? 6'h00 : divCnt + 6'h01;
                if (halfTick) begin
                    sckOut  <= !sckOut;
                    halfCnt <= halfCnt + 4'h1;
                    busy    <= halfCnt != LAST_HALF;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Shift buffer and serial data out
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sh     <= RST_DATA;
            bitCnt <= 4'h0;
            sdoOut <= 1'b1;
        end else if (ce) begin
            if (wrData && !busyAny) begin
                sh <= pwdata[7:0];
            end else if (capture) begin
                sh <= rxWord;
            end
            if (earlyDesel || !(isMaster || slvSel)) begin
                bitCnt <= 4'h0;
            end else if (capture) begin
                bitCnt <= wordDone ? 4'h0 : bitCnt + 4'h1;
            end
            if (start) begin
                sdoOut <= msbFirst ? pwdata[7] : pwdata[0];
            end else if (launch) begin
                sdoOut <= msbFirst ? sh[7] : sh[0];
            end else if (!busyAny && !(slvSel && edgeSel)) begin
                sdoOut <= 1'b1;
            end else if (!busyAny) begin
                sdoOut <= msbFirst ? sh[7] : sh[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers with hardware-set flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modeReg <= RST_MODE;
            ctrlReg <= RST_CTRL;
            statReg <= RST_STAT;
            toutReg <= RST_TOUT;
            pinsReg <= RST_PINS;
            dataReg <= RST_DATA;
        end else if (ce) begin
            if (wrMode) modeReg <= pwdata[7:0];
            if (wrCtrl) ctrlReg <= pwdata[7:0];
            if (wrStat) statReg <= (statReg & ~STAT_WMASK) | (pwdata[7:0] & STAT_WMASK);
            if (wrTout) toutReg <= pwdata[7:0];
            if (wrPins) pinsReg <= pwdata[7:0];
            if (wrData && !busyAny) dataReg <= pwdata[7:0];
            // Done reads low while shifting; a hardware set still wins
            if (start || (capture && bitCnt == 4'h0)) begin
                ctrlReg[SC_DONE] <= 1'b0;
            end
            if (wordDone) begin
                dataReg          <= rxWord;
                ctrlReg[SC_DONE] <= 1'b1;
            end
            if (wrData && busyAny) ctrlReg[SC_WRITE_COLLISION_FLAG] <= 1'b1;
            if (earlyDesel) begin
                modeReg[MD_ICF]  <= 1'b1;
                ctrlReg[SC_DONE] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin enables and I2C front end
    // ------------------------------------------------------------
    logic [2:0] debCnt, debNeed;

    always_comb begin
        case (modeReg[MD_DEB_LO+:2])
            2'h0:    debNeed = 3'h0;
            2'h1:    debNeed = DEB_TWO;
            default: debNeed = DEB_FOUR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sckOe        <= 1'b0;
            sdoOe        <= 1'b0;
            sdaOut       <= 1'b0;
            sdaOe        <= 1'b0;
            sclOut       <= 1'b0;
            sclOe        <= 1'b0;
            pullUpEn     <= 2'h0;
            pinSerialSel <= 1'b0;
        end else if (ce) begin
            sckOe        <= isMaster;
            sdoOe        <= isMaster || isSlave;
            sdaOut       <= 1'b0;
            sdaOe        <= 1'b0;
            sclOut       <= 1'b0;
            sclOe        <= 1'b0;
            pullUpEn     <= pinsReg[1:0];
            pinSerialSel <= isMaster || isSlave || isI2c;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            debCnt   <= 3'h0;
            sclLevel <= 1'b1;
        end else if (ce) begin
            if (!isI2c || sclS == sclLevel) begin
                debCnt <= 3'h0;
                if (!isI2c) sclLevel <= 1'b1;
            end else if (debCnt + 3'h1 >= debNeed) begin
                debCnt   <= 3'h0;
                sclLevel <= sclS;
            end else begin
                debCnt <= debCnt + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_sck_idle_level: assert property (ce && isMaster && !busy |=> sckOut == $past(!idleLow))
        else $error("master SCK not at idle level");
    a_slave_no_sck: assert property (ce && !isMaster |=> !sckOe)
        else $error("SCK driven outside master mode");
    a_write_collides: assert property (ce && wrData && busyAny |=> ctrlReg[SC_WRITE_COLLISION_FLAG])
        else $error("collision flag not set");
    a_write_starts: assert property (ce && start |=> busy && !ctrlReg[SC_DONE])
        else $error("write did not start master word");
    a_word_lands: assert property (ce && wordDone |=> ctrlReg[SC_DONE] && dataReg == $past(rxWord))
        else $error("word not copied on completion");
    a_early_deselect: assert property (ce && earlyDesel |=> modeReg[MD_ICF] && ctrlReg[SC_DONE])
        else $error("incomplete flag missing");
    a_capture_edge: assert property (ce && capture && isMaster |-> halfCnt[0] == !edgeSel)
        else $error("master capture on wrong edge");
    a_idle_sdo_high: assert property (ce && isMaster && !busy && !wrData |=> sdoOut && sdoOe)
        else $error("idle SDO not driven high");
    a_pins_released: assert property (ce && !en |=> !pinSerialSel && !sckOe && !sdoOe)
        else $error("pins held while disabled");
    a_debounce_two: assert property (ce && isI2c && debNeed == DEB_TWO && sclS != sclLevel
                                     && debCnt == 3'h1 |=> sclLevel == $past(sclS))
        else $error("debounce did not settle after two clocks");
    a_open_drain: assert property (!sdaOut && !sclOut)
        else $error("I2C line driven high");
endmodule

/* File: tb/spi_far_end.sv */
// Far-end SPI slave: shifts a preset byte out MSB first and collects the master's bits.
// Assumes sck and mosi are settled levels that it may sample on clk.
`timescale 1ns/1ps
module spi_far_end (
    input  wire logic       clk,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       capRise,
    input  wire logic       load,
    input  wire logic [7:0] txByte,
    output logic      [7:0] rxByte,
    output logic            miso
);
    logic [7:0] tx = 8'h00;
    logic       sckQ = 1'b1;
    assign miso = tx[7];
    always_ff @(posedge clk) begin
        sckQ <= sck;
        if (load) begin
            tx <= txByte;
        end else if (sck != sckQ && sck == capRise) begin
            rxByte <= {rxByte[6:0], mosi};
            // Fill bit is the inverse of the old bit 0 so a stale line never matches
            tx     <= {tx[6:0], ~tx[0]};
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the combined serial port: APB master, SPI far end, I2C clock.
// Assumes the design answers APB with one wait state.
`timescale 1ns/1ps
module tb_top;
    import sync_serial_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, rnd = 8'h1f, rdv, pre = 8'h00, sent, got, txv, farRx;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        subClk = 1'b0, timerMatch = 1'b0, sclIn = 1'b1, load = 1'b0, errv;
    logic        pready, pslverr, sckOut, sckOe, sdoOut, sdaOe, sclOe, sclLevel, pinSerialSel;
    logic        miso, sdoOe, sdaOut, sclOut, slvSck = 1'b1, ssnTb = 1'b1, mosiTb = 1'b0;
    logic [1:0]  pullUpEn;
    int          errTotal = 0, totalChecks = 0;
    always #10 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        subClk <= ~subClk;
    end
    always begin
        repeat (2) @(posedge clk);
        timerMatch <= 1'b1;
        @(posedge clk);
        timerMatch <= 1'b0;
    end
    sync_serial_port sync_serial_port_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sckIn(sckOe ? sckOut : slvSck), .sckOut(sckOut),
        .sckOe(sckOe), .sdiIn(sckOe ? miso : mosiTb), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .slaveSelectN(ssnTb), .subClk(subClk), .timerMatch(timerMatch), .sdaIn(1'b1),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
        .sclLevel(sclLevel), .pullUpEn(pullUpEn), .pinSerialSel(pinSerialSel));
    spi_far_end spi_far_end_i (.clk(clk), .sck(sckOut), .mosi(sdoOut), .capRise(1'b1),
        .load(load), .txByte(pre), .rxByte(farRx), .miso(miso));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] modeVal(input logic [2:0] m);
        return {m, 5'b00010};
    endfunction
    task automatic wrapUp();
        $display("Checks %0d errors %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errTotal++;
        rdv = prdata[7:0];
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // External master: one bit per SCK period, MOSI set on the falling edge
    task automatic slvBits(input logic [7:0] v, input int k);
        for (int i = 7; i > 7 - k; i--) begin
            slvSck <= 1'b0;
            mosiTb <= v[i];
            repeat (4) @(posedge clk);
            got[i] = sdoOut;
            slvSck <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic xfer(input logic [2:0] m);
        logic [7:0] c;
        int n;
        c = {2'b00, m[0], m[0], 4'b1100};
        apb(1'b1, OFS_CTRL, c);
        apb(1'b1, OFS_MODE, modeVal(m));
        check("idle", {7'h0, sckOut}, {7'h0, ~m[0]});
        rnd = lfsr(rnd);
        pre <= rnd;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        rnd = lfsr(rnd);
        sent = rnd;
        apb(1'b1, OFS_DATA, sent);
        apb(1'b1, OFS_DATA, ~sent);
        apb(1'b0, OFS_DATA, 8'h00);
        check("busyData", rdv, sent);
        apb(1'b0, OFS_CTRL, 8'h00);
        check("busyCtrl", rdv, c | 8'h02);
        n = 0;
        while (rdv[0] !== 1'b1 && n < 300) begin
            apb(1'b0, OFS_CTRL, 8'h00);
            n++;
        end
        check("doneCtrl", rdv, c | 8'h03);
        apb(1'b0, OFS_DATA, 8'h00);
        check("rxData", rdv, pre);
        check("farRx", farRx, sent);
        apb(1'b1, OFS_CTRL, c);
        apb(1'b0, OFS_CTRL, 8'h00);
        check("clear", rdv, c);
    endtask
    initial begin
        #400000;
        errTotal++;
        wrapUp();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_MODE, 8'h00);
        check("mode", rdv, RST_MODE);
        apb(1'b0, OFS_STAT, 8'h00);
        check("stat", rdv, 8'h00);
        apb(1'b0, 8'h20, 8'h00);
        check("slverr", {7'h0, errv}, 8'h01);
        check("pinOff", {7'h0, pinSerialSel}, 8'h00);
        for (int m = 0; m < 5; m++) begin
            xfer(m[2:0]);
        end
        apb(1'b1, OFS_MODE, modeVal(MODE_SLAVE));
        @(posedge clk);
        check("slvSckOe", {7'h0, sckOe}, 8'h00);
        check("slvSdo", {7'h0, sdoOut}, 8'h01);
        check("slvSdoOe", {7'h0, sdoOe}, 8'h01);
        // Select pin off: the slave must run although its select input stays high
        apb(1'b1, OFS_CTRL, 8'h08);
        rnd = lfsr(rnd);
        txv = rnd;
        apb(1'b1, OFS_DATA, txv);
        rnd = lfsr(rnd);
        sent = rnd;
        slvBits(sent, 8);
        check("slvTx", got, txv);
        apb(1'b0, OFS_CTRL, 8'h00);
        check("slvDone", rdv, 8'h09);
        apb(1'b0, OFS_DATA, 8'h00);
        check("slvRx", rdv, sent);
        // Select pin on, master lets go of select after three bits
        apb(1'b1, OFS_CTRL, 8'h0c);
        ssnTb <= 1'b0;
        repeat (2) @(posedge clk);
        slvBits(sent, 3);
        ssnTb <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, OFS_MODE, 8'h00);
        check("slvIcf", rdv, modeVal(MODE_SLAVE) | 8'h01);
        apb(1'b0, OFS_CTRL, 8'h00);
        check("slvPart", rdv, 8'h0d);
        apb(1'b1, OFS_MODE, modeVal(MODE_I2C) | 8'h08);
        apb(1'b0, OFS_STAT, 8'h00);
        check("i2cStat", rdv, RST_STAT);
        apb(1'b1, OFS_PINS, 8'h03);
        // One-cycle SCL glitch passes only with no filtering
        for (int d = 0; d < 3; d++) begin
            apb(1'b1, OFS_MODE, modeVal(MODE_I2C) | {4'h0, d[1:0], 2'b00});
            sclIn <= 1'b0;
            repeat (8) @(posedge clk);
            check("sclLow", {7'h0, sclLevel}, 8'h00);
            sclIn <= 1'b1;
            @(posedge clk);
            sclIn <= 1'b0;
            repeat (3) @(posedge clk);
            check("sclGlitch", {7'h0, sclLevel}, {7'h0, d == 0});
            sclIn <= 1'b1;
            repeat (8) @(posedge clk);
            check("sclHigh", {7'h0, sclLevel}, 8'h01);
        end
        check("pull", {6'h0, pullUpEn}, 8'h03);
        check("odOe", {4'h0, sdaOut, sclOut, sdaOe, sclOe}, 8'h00);
        // Enable set but asynchronous mode selected: the unit stays off
        apb(1'b1, OFS_MODE, 8'h12);
        @(posedge clk);
        check("pinRel", {7'h0, pinSerialSel}, 8'h00);
        wrapUp();
    end
endmodule
